/* File: hw/i2c_dual_ptr.sv */
// Function
// - read data starts on next SCL clock
// - register pointer auto-increments after each byte
// - register current read mirrors memory current read
// - separate memory and register pointers
// - updating one pointer leaves other unchanged
// - memory read resumes at retained pointer
// - two-byte memory address, MSB first, masked
// - register address above 18h is refused
// - memory pointer wraps at the ADDR_W mask to 0000h (7FFFh at the default width)
// - pointer increments after byte, before acknowledge
// - master acknowledge continues read, none ends
`timescale 1ns/1ps
`default_nettype none
module i2c_dual_ptr #(
  parameter int ADDR_W = i2c_dual_ptr_pkg::MEM_AW_DEF
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_link_clk,
  input  wire logic                      i_scl,
  input  wire logic                      i_sda,
  output logic                           o_sda,
  output logic                           o_sda_oe,
  output i2c_dual_ptr_pkg::acc_type      o_acc,
  output logic                           o_acc_valid,
  input  wire logic                      i_acc_ready,
  input  wire logic                      i_rd_valid,
  input  wire logic [7:0]                i_rd_data
);
  import i2c_dual_ptr_pkg::*;

  localparam logic [14:0] MEM_MASK = 15'((33'h1_0000_0000 >> (32 - ADDR_W)) - 1);
  localparam logic [4:0]  REG_WRAP = REG_LAST[4:0];
  typedef struct packed {
    link_st_type st;
    link_st_type after_ack;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [7:0]  shreg;
    logic [3:0]  cnt;
    space_type   space;
    logic [7:0]  addr_hi;
    logic [14:0] mem_ptr;
    logic [4:0]  reg_ptr;
    logic        sda_drive;
    logic        req_tgl;
    acc_type     req;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic [7:0]  rd_byte;
  } link_state_type;
  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    acc_type     ent0;
    acc_type     ent1;
    logic        wp;
    logic        rp;
    logic [1:0]  count;
    logic        rd_wait;
    logic        ack_tgl;
    logic [7:0]  rsp_data;
  } core_state_type;
  link_state_type l;
  link_state_type next_l;
  core_state_type c;
  core_state_type next_c;

  // ---------------- link domain ----------------
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] byte_in;
    rise    = l.scl_s2 & ~l.scl_d;
    fall    = ~l.scl_s2 & l.scl_d;
    start   = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2;
    stop    = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
    byte_in = l.shreg;
    next_l  = l;
    next_l.scl_s1 = i_scl;
    next_l.scl_s2 = l.scl_s1;
    next_l.scl_d  = l.scl_s2;
    next_l.sda_s1 = i_sda;
    next_l.sda_s2 = l.sda_s1;
    next_l.sda_d  = l.sda_s2;
    next_l.ack_s1 = c.ack_tgl;
    next_l.ack_s2 = l.ack_s1;
    // response word is stable once its toggle is seen
    if (l.ack_s2 != l.ack_seen) begin
      next_l.ack_seen = l.ack_s2;
      next_l.rd_byte  = c.rsp_data;
    end
    if (start) begin
      next_l.st        = L_DEV;
      next_l.cnt       = '0;
      next_l.sda_drive = 1'b0;
    end else if (stop) begin
      next_l.st        = L_IDLE;
      next_l.sda_drive = 1'b0;
    end else begin
      case (l.st)
        L_DEV, L_AHI, L_ALO, L_REGA, L_WDATA: begin
          if (rise && l.cnt != BITS_PER_BYTE) begin
            next_l.shreg = {l.shreg[6:0], l.sda_s2};
            next_l.cnt   = l.cnt + 4'h1;
          end else if (fall && l.cnt == BITS_PER_BYTE) begin
            next_l.cnt       = '0;
            next_l.sda_drive = 1'b1;
            next_l.st        = L_ACKOUT;
            case (l.st)
              L_DEV: begin
                if (byte_in[7:1] == MEM_DEV_ADDR || byte_in[7:1] == REG_DEV_ADDR) begin
                  next_l.space = (byte_in[7:1] == REG_DEV_ADDR) ? SPACE_REG : SPACE_MEM;
                  if (byte_in[0]) begin
                    // fetch from the retained pointer of the selected space
                    next_l.req_tgl    = ~l.req_tgl;
                    next_l.req.wr     = 1'b0;
                    next_l.req.space  = next_l.space;
                    next_l.req.addr   = (next_l.space == SPACE_REG) ? {10'h000, l.reg_ptr}
                                                                    : l.mem_ptr;
                    next_l.req.data   = '0;
                    next_l.after_ack  = L_RDATA;
                  end else begin
                    // writes always carry a fresh address
                    next_l.after_ack = (next_l.space == SPACE_REG) ? L_REGA : L_AHI;
                  end
                end else begin
                  next_l.sda_drive = 1'b0;
                  next_l.st        = L_IDLE;
                end
              end
              L_AHI: begin
                next_l.addr_hi   = byte_in;
                next_l.after_ack = L_ALO;
              end
              L_ALO: begin
                next_l.mem_ptr   = {l.addr_hi[6:0], byte_in} & MEM_MASK;
                next_l.after_ack = L_WDATA;
              end
              L_REGA: begin
                if (byte_in > REG_LAST) begin
                  next_l.sda_drive = 1'b0;
                  next_l.st        = L_IDLE;
                end else begin
                  next_l.reg_ptr   = byte_in[4:0];
                  next_l.after_ack = L_WDATA;
                end
              end
              default: begin
                next_l.req_tgl   = ~l.req_tgl;
                next_l.req.wr    = 1'b1;
                next_l.req.space = l.space;
                next_l.req.addr  = (l.space == SPACE_REG) ? {10'h000, l.reg_ptr} : l.mem_ptr;
                next_l.req.data  = byte_in;
                // bump only the active pointer, before the acknowledge
                if (l.space == SPACE_REG) begin
                  next_l.reg_ptr = (l.reg_ptr == REG_WRAP) ? '0 : l.reg_ptr + 5'h01;
                end else begin
                  next_l.mem_ptr = (l.mem_ptr + 15'h0001) & MEM_MASK;
                end
                next_l.after_ack = L_WDATA;
              end
            endcase
          end
        end
        L_ACKOUT: begin
          if (fall) begin
            next_l.st        = l.after_ack;
            next_l.sda_drive = 1'b0;
            if (l.after_ack == L_RDATA) begin
              next_l.shreg     = l.rd_byte;
              next_l.sda_drive = ~l.rd_byte[7];
              next_l.cnt       = 4'h1;
            end
          end
        end
        L_RDATA: begin
          if (fall) begin
            if (l.cnt == BITS_PER_BYTE) begin
              next_l.sda_drive = 1'b0;
              next_l.st        = L_ACKIN;
              if (l.space == SPACE_REG) begin
                next_l.reg_ptr = (l.reg_ptr == REG_WRAP) ? '0 : l.reg_ptr + 5'h01;
              end else begin
                next_l.mem_ptr = (l.mem_ptr + 15'h0001) & MEM_MASK;
              end
              // prefetch the next byte so it is ready for the master acknowledge
              next_l.req_tgl   = ~l.req_tgl;
              next_l.req.wr    = 1'b0;
              next_l.req.space = l.space;
              next_l.req.addr  = (l.space == SPACE_REG) ? {10'h000, next_l.reg_ptr}
                                                        : next_l.mem_ptr;
              next_l.req.data  = '0;
            end else begin
              next_l.shreg     = {l.shreg[6:0], 1'b0};
              next_l.sda_drive = ~l.shreg[6];
              next_l.cnt       = l.cnt + 4'h1;
            end
          end
        end
        L_ACKIN: begin
          if (rise) begin
            next_l.st = l.sda_s2 ? L_IDLE : L_ACKGO;
          end
        end
        L_ACKGO: begin
          if (fall) begin
            next_l.shreg     = l.rd_byte;
            next_l.sda_drive = ~l.rd_byte[7];
            next_l.cnt       = 4'h1;
            next_l.st        = L_RDATA;
          end
        end
        default: next_l.st = L_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      l           <= '0;
      l.st        <= L_IDLE;
      l.after_ack <= L_IDLE;
      l.scl_s1    <= 1'b1;
      l.scl_s2    <= 1'b1;
      l.scl_d     <= 1'b1;
      l.sda_s1    <= 1'b1;
      l.sda_s2    <= 1'b1;
      l.sda_d     <= 1'b1;
      l.mem_ptr   <= MEM_PTR_RST;
      l.reg_ptr   <= REG_PTR_RST;
    end else begin
      l <= next_l;
    end
  end

  assign o_sda    = 1'b0;
  assign o_sda_oe = l.sda_drive;

  // ---------------- core domain ----------------
  always_comb begin
    logic    push;
    logic    pop;
    acc_type head;
    head   = c.rp ? c.ent1 : c.ent0;
    pop    = o_acc_valid & i_acc_ready;
    push   = (c.req_s2 != c.req_seen) && (c.count != 2'h2 || pop);
    next_c = c;
    next_c.req_s1 = l.req_tgl;
    next_c.req_s2 = c.req_s1;
    // request word held steady by the link until it issues its next request
    if (push) begin
      next_c.req_seen = c.req_s2;
      if (c.wp) begin
        next_c.ent1 = l.req;
      end else begin
        next_c.ent0 = l.req;
      end
      next_c.wp = ~c.wp;
      if (l.req.wr) begin
        next_c.ack_tgl = ~c.ack_tgl;
      end
    end
    if (pop) begin
      next_c.rp      = ~c.rp;
      next_c.rd_wait = ~head.wr;
    end
    next_c.count = c.count + {1'b0, push} - {1'b0, pop};
    if (c.rd_wait && i_rd_valid) begin
      next_c.rd_wait  = 1'b0;
      next_c.rsp_data = i_rd_data;
      next_c.ack_tgl  = ~c.ack_tgl;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end
  // one read in flight at a time keeps answers in order
  assign o_acc       = c.rp ? c.ent1 : c.ent0;
  assign o_acc_valid = (c.count != 2'h0) && !c.rd_wait;
endmodule : i2c_dual_ptr
`default_nettype wire

/* File: hw/i2c_dual_ptr_pkg.sv */
package i2c_dual_ptr_pkg;
  // density and address field layout
  localparam int          MEM_AW_MAX    = 15;
  localparam int          MEM_AW_DEF    = 15;
  localparam int          REG_AW        = 5;
  localparam logic [7:0]  REG_LAST      = 8'h18;
  // device identifiers: values arbitrary
  localparam logic [6:0]  MEM_DEV_ADDR  = 7'h50;
  localparam logic [6:0]  REG_DEV_ADDR  = 7'h68;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [14:0] MEM_PTR_RST   = 15'h0000;
  localparam logic [4:0]  REG_PTR_RST   = 5'h00;

  typedef enum logic {SPACE_MEM, SPACE_REG} space_type;

  typedef struct packed {
    logic        wr;
    space_type   space;
    logic [14:0] addr;
    logic [7:0]  data;
  } acc_type;

  typedef enum logic [3:0] {
    L_IDLE, L_DEV, L_AHI, L_ALO, L_REGA, L_WDATA, L_ACKOUT, L_RDATA, L_ACKIN, L_ACKGO
  } link_st_type;
endpackage : i2c_dual_ptr_pkg

/* File: testbench/i2c_dual_ptr_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_dual_ptr_bench;
  import i2c_dual_ptr_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_link_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_acc_ready = 1'b1;
  logic       i_rd_valid = 1'b0;
  logic [7:0] i_rd_data = 8'h00;
  logic [7:0] rsp = 8'h00;
  logic       scl, sda_low, oe, acc_valid, pend;
  acc_type    acc;
  logic [7:0] mem [0:8191];
  logic [7:0] regs [0:31];
  int         n_mismatch = 0;
  int         check_count = 0;
  wire        sda = !(sda_low || oe);

  always #5 i_clk = !i_clk;
  initial begin
    #3;
    forever #62.5 i_link_clk = !i_link_clk;
  end
  i2c_master_model m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  i2c_dual_ptr #(.ADDR_W(13)) uut (.i_clk, .i_rst_b, .i_link_clk, .i_scl(scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(oe), .o_acc(acc), .o_acc_valid(acc_valid), .i_acc_ready,
    .i_rd_valid, .i_rd_data);

  function automatic logic [7:0] pat(input logic [14:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : pat
  // answer comes a cycle after the take; data line scrambled outside the pulse
  always @(posedge i_clk) begin
    pend = acc_valid && i_acc_ready && !acc.wr;
    if (acc_valid && i_acc_ready) begin
      if (acc.space == SPACE_REG) begin
        if (acc.wr) regs[acc.addr[4:0]] = acc.data;
        rsp = regs[acc.addr[4:0]];
      end else begin
        if (acc.wr) mem[acc.addr[12:0]] = acc.data;
        rsp = mem[acc.addr[12:0]];
      end
    end
  end
  always @(negedge i_clk) begin
    i_rd_valid <= pend;
    i_rd_data <= pend ? rsp : ~rsp;
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic set_ptr(input logic [6:0] dev, input logic [15:0] a, input logic two,
                         output logic k);
    m.start();
    m.wbyte({dev, 1'b0}, k);
    if (two) m.wbyte(a[15:8], k);
    m.wbyte(a[7:0], k);
  endtask : set_ptr
  task automatic rd(input logic [6:0] dev, input logic [14:0] a, input int n);
    logic [7:0] d;
    logic       k;
    m.start();
    m.wbyte({dev, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk("read byte", d, pat(a + 15'(i)));
    end
    m.stop();
  endtask : rd

  task automatic test_write_wrap;
    logic k;
    @(negedge i_clk) i_acc_ready = 1'b0;
    set_ptr(MEM_DEV_ADDR, 16'hffff, 1'b1, k);
    chk("mem addr ack", k, 1'b1);
    m.wbyte(8'ha5, k);
    m.wbyte(8'h5a, k);
    chk("stalled word held", acc_valid, 1'b1);
    @(negedge i_clk) i_acc_ready = 1'b1;
    m.wbyte(8'h96, k);
    m.stop();
    chk("top of memory", mem[13'h1fff], 8'ha5);
    chk("wrapped", mem[13'h0000], 8'h5a);
    chk("after wrap", mem[13'h0001], 8'h96);
    $display("test_write_wrap done");
  endtask : test_write_wrap
  task automatic test_reg_write;
    logic k;
    set_ptr(REG_DEV_ADDR, 16'h0017, 1'b0, k);
    m.wbyte(8'h11, k);
    m.wbyte(8'h22, k);
    m.stop();
    chk("reg 17h", regs[5'h17], 8'h11);
    chk("reg 18h", regs[5'h18], 8'h22);
    chk("mem 17h untouched", mem[13'h0017], pat(15'h0017));
    rd(REG_DEV_ADDR, 15'h0000, 1);
    $display("test_reg_write done");
  endtask : test_reg_write
  task automatic test_interleave;
    logic k;
    set_ptr(MEM_DEV_ADDR, 16'h0100, 1'b1, k);
    rd(MEM_DEV_ADDR, 15'h0100, 2);
    set_ptr(REG_DEV_ADDR, 16'h0005, 1'b0, k);
    m.stop();
    rd(REG_DEV_ADDR, 15'h0005, 2);
    rd(MEM_DEV_ADDR, 15'h0102, 1);
    $display("test_interleave done");
  endtask : test_interleave
  task automatic test_refuse;
    logic k;
    set_ptr(REG_DEV_ADDR, 16'h0018, 1'b0, k);
    chk("reg 18h ack", k, 1'b1);
    set_ptr(REG_DEV_ADDR, 16'h0019, 1'b0, k);
    chk("reg 19h refused", k, 1'b0);
    m.wbyte(8'h00, k);
    chk("abandoned", k, 1'b0);
    m.stop();
    m.start();
    m.wbyte({7'h11, 1'b0}, k);
    chk("foreign id ignored", k, 1'b0);
    m.stop();
    $display("test_refuse done");
  endtask : test_refuse

  initial begin
    for (int a = 0; a < 8192; a++) mem[a] = pat(15'(a));
    for (int a = 0; a < 32; a++) regs[a] = pat(15'(a));
    repeat (8) @(negedge i_clk);
    i_rst_b = 1'b1;
    #1000;
    test_write_wrap();
    test_reg_write();
    test_interleave();
    test_refuse();
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : i2c_dual_ptr_bench
`default_nettype wire

/* File: testbench/i2c_dual_ptr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_dual_ptr_properties
  import i2c_dual_ptr_pkg::*;
#(
  parameter int ADDR_W = MEM_AW_DEF
) (
  input wire logic                      i_clk,
  input wire logic                      i_rst_b,
  input wire logic                      i_link_clk,
  input wire logic                      i_scl,
  input wire logic                      o_sda,
  input wire logic                      o_sda_oe,
  input wire i2c_dual_ptr_pkg::acc_type o_acc,
  input wire logic                      o_acc_valid,
  input wire logic                      i_acc_ready,
  input wire logic                      i_rd_valid
);
  // one read may be in flight; set on its take, cleared by the answer
  logic pend;
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b) pend <= 1'b0;
    else if (i_rd_valid) pend <= 1'b0;
    else if (o_acc_valid && i_acc_ready && !o_acc.wr) pend <= 1'b1;

  AST_VALID_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) o_acc_valid && !i_acc_ready |=> o_acc_valid
  ) else $error("access word dropped before taken");
  AST_WORD_STABLE: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) o_acc_valid && !i_acc_ready |=> $stable(o_acc)
  ) else $error("access word changed before taken");
  AST_READ_WAIT: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) pend |-> !o_acc_valid
  ) else $error("new word while read outstanding");
  AST_REG_RANGE: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
      o_acc_valid && o_acc.space == SPACE_REG |-> o_acc.addr <= {7'h00, REG_LAST}
  ) else $error("register address out of range");
  AST_MEM_MASK: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
      o_acc_valid && o_acc.space == SPACE_MEM |-> (o_acc.addr >> ADDR_W) == 15'h0000
  ) else $error("memory address above density");
  AST_OPEN_DRAIN: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_b) o_sda == 1'b0
  ) else $error("data pin driven high");
  AST_OE_SCL_HIGH: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_b) i_scl && $past(i_scl) |-> $stable(o_sda_oe)
  ) else $error("data changed while clock high");
  AST_OE_RELEASE: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_b) $rose(o_sda_oe) |-> ##[1:200] !o_sda_oe
  ) else $error("data line held too long");
endmodule : i2c_dual_ptr_properties

bind i2c_dual_ptr i2c_dual_ptr_properties #(.ADDR_W(ADDR_W)) props (
  .i_clk, .i_rst_b, .i_link_clk, .i_scl, .o_sda, .o_sda_oe, .o_acc, .o_acc_valid,
  .i_acc_ready, .i_rd_valid);
`default_nettype wire

/* File: testbench/i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 500
) (
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  // clock stands high between frames; data relies on the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask : bit_io
  task automatic start;
    o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    o_sda_low = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_low = 1'b0;
    #Q;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire
